/* core/dtec_pkg.sv */
// Constants shared by the dual timer/event counter block.
package dtec_pkg;

    // ****************************************************************
    // Register indices on the data memory port
    // ****************************************************************
    localparam logic [2:0] DTEC_T8_COUNT = 3'h0;
    localparam logic [2:0] DTEC_T8_CONTROL = 3'h1;
    localparam logic [2:0] DTEC_T16_LOW = 3'h2;
    localparam logic [2:0] DTEC_T16_HIGH = 3'h3;
    localparam logic [2:0] DTEC_T16_CONTROL = 3'h4;

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int DTEC_MODE_HI = 7;
    localparam int DTEC_MODE_LO = 6;
    localparam int DTEC_SRC_BIT = 5;
    localparam int DTEC_RUN_BIT = 4;
    localparam int DTEC_EDGE_BIT = 3;
    localparam int DTEC_PSC_HI = 2;
    localparam int DTEC_PSC_LO = 0;

    localparam logic [1:0] DTEC_MODE_IDLE = 2'h0;
    localparam logic [1:0] DTEC_MODE_EVENT = 2'h1;
    localparam logic [1:0] DTEC_MODE_TIMER = 2'h2;
    localparam logic [1:0] DTEC_MODE_PULSE = 2'h3;

    // ****************************************************************
    // Reset values and timing
    // ****************************************************************
    localparam logic [7:0] DTEC_CTRL_RST = 8'h00;
    localparam logic [7:0] DTEC_PRE_RST = 8'h00;
    localparam logic [1:0] DTEC_DIV4_LAST = 2'h3;
    localparam logic [7:0] DTEC_FULL8 = 8'hff;
    localparam logic [15:0] DTEC_FULL16 = 16'hffff;

endpackage

/* core/dtec_top.sv */
// Dual timer/event counter: 8-bit prescaled and 16-bit buffered counters.
`timescale 1ns/1ns

module dtec_top import dtec_pkg::*; #(
    parameter bit HAS_T16 = 1'b1,      // Build the 16-bit counter.
    parameter bit T16_LOW_SPEED_INTERNAL_OSCILLATOR_OPT = 1'b1  // Allow slow oscillator source.
) (
    input wire logic clock_i,          // System clock, 100 MHz.
    input wire logic nrst_i,           // Asynchronous reset, active low.
    input wire logic ce_i,             // Clock enable; low freezes state.
    input wire logic [2:0] addr_i,     // Register index.
    input wire logic wr_i,             // Write strobe.
    input wire logic rd_i,             // Read strobe.
    input wire logic [7:0] wdata_i,    // Write data.
    input wire logic t8_pin_i,         // 8-bit counter event pin.
    input wire logic t16_event_pin_i,  // 16-bit counter event pin.
    input wire logic low_speed_internal_oscillator_clk_i,       // Slow internal oscillator level.
    input wire logic int_en8_i,        // 8-bit overflow request enable.
    input wire logic int_en16_i,       // 16-bit overflow request enable.
    output logic [7:0] rdata_o,        // Read data, held until next read.
    output logic irq8_o,               // 8-bit overflow request pulse.
    output logic irq16_o               // 16-bit overflow request pulse.
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [2:0] p8_sync;
        logic [2:0] p16_sync;
        logic [2:0] low_speed_internal_oscillator_sync;
        logic p8_lvl;
        logic p16_lvl;
        logic low_speed_internal_oscillator_lvl;
        logic [7:0] psc_cnt;
        logic [1:0] div4;
        logic [7:0] cnt8;
        logic [7:0] pre8;
        logic [7:0] ctl8;
        logic [15:0] cnt16;
        logic [15:0] pre16;
        logic [7:0] ctl16;
        logic [7:0] lowbuf;
        logic [7:0] rdata;
        logic pw8;
        logic pw16;
        logic irq8;
        logic irq16;
    } dtec_state_t;

    dtec_state_t state_reg;
    dtec_state_t state_next;

    // Counting condition for one counter given its control byte.
    function automatic logic count_now(input logic [7:0] ctl,
                                       input logic pin_edge,
                                       input logic pw,
                                       input logic itick);
        logic [1:0] md;
        md = ctl[DTEC_MODE_HI:DTEC_MODE_LO];
        count_now = 1'b0;
        if (ctl[DTEC_RUN_BIT]) begin
            case (md)
                DTEC_MODE_TIMER: count_now = itick;
                DTEC_MODE_EVENT: count_now = pin_edge;
                DTEC_MODE_PULSE: count_now = pw & itick;
                default: count_now = 1'b0;
            endcase
        end
    endfunction

    // Filtered pin level: accept a change once stages two and three agree.
    function automatic logic filt(input logic [2:0] s, input logic lvl);
        filt = (s[1] == s[2]) ? s[2] : lvl;
    endfunction

    logic p8_n, p16_n, low_speed_internal_oscillator_n;
    logic rise8, fall8, rise16, fall16, low_speed_internal_oscillator_rise;
    logic ev8, ev16, beg8, beg16, end8, end16;
    logic tick8, tick16, inc8, inc16, ovf8, ovf16;
    logic [7:0] psc_mask;
    logic [7:0] ctl16_eff;

    // ****************************************************************
    // Pin filtering and internal clock sources
    // ****************************************************************
    // Pins are asynchronous; only stages two and three are ever compared.
    assign p8_n = filt(state_reg.p8_sync, state_reg.p8_lvl);
    assign p16_n = filt(state_reg.p16_sync, state_reg.p16_lvl);
    assign low_speed_internal_oscillator_n = filt(state_reg.low_speed_internal_oscillator_sync, state_reg.low_speed_internal_oscillator_lvl);
    assign rise8 = p8_n & ~state_reg.p8_lvl;
    assign fall8 = ~p8_n & state_reg.p8_lvl;
    assign rise16 = p16_n & ~state_reg.p16_lvl;
    assign fall16 = ~p16_n & state_reg.p16_lvl;
    assign low_speed_internal_oscillator_rise = low_speed_internal_oscillator_n & ~state_reg.low_speed_internal_oscillator_lvl;

    // Edge bit low: event on rising, pulse of low level measured.
    assign ev8 = state_reg.ctl8[DTEC_EDGE_BIT] ? fall8 : rise8;
    assign ev16 = state_reg.ctl16[DTEC_EDGE_BIT] ? fall16 : rise16;
    assign beg8 = state_reg.ctl8[DTEC_EDGE_BIT] ? rise8 : fall8;
    assign beg16 = state_reg.ctl16[DTEC_EDGE_BIT] ? rise16 : fall16;
    assign end8 = state_reg.ctl8[DTEC_EDGE_BIT] ? fall8 : rise8;
    assign end16 = state_reg.ctl16[DTEC_EDGE_BIT] ? fall16 : rise16;

    // Prescale ratio is 2 to the power of the rate field.
    assign psc_mask = 8'((9'h1 << state_reg.ctl8[DTEC_PSC_HI:DTEC_PSC_LO])
                         - 9'h1);
    assign tick8 = (state_reg.psc_cnt & psc_mask) == psc_mask;
    assign tick16 = (T16_LOW_SPEED_INTERNAL_OSCILLATOR_OPT && state_reg.ctl16[DTEC_SRC_BIT])
                    ? low_speed_internal_oscillator_rise
                    : (state_reg.div4 == DTEC_DIV4_LAST);

    // An absent 16-bit counter reads as idle and never counts.
    assign ctl16_eff = HAS_T16 ? state_reg.ctl16 : DTEC_CTRL_RST;

    assign inc8 = count_now(state_reg.ctl8, ev8, state_reg.pw8, tick8);
    assign inc16 = count_now(ctl16_eff, ev16, state_reg.pw16, tick16);
    assign ovf8 = inc8 && state_reg.cnt8 == DTEC_FULL8;
    assign ovf16 = inc16 && state_reg.cnt16 == DTEC_FULL16;

    // ****************************************************************
    // Next state
    // ****************************************************************
    // Register writes are applied last so software wins over counting.
    always_comb begin
        state_next = state_reg;
        state_next.p8_sync = {state_reg.p8_sync[1:0], t8_pin_i};
        state_next.p16_sync = {state_reg.p16_sync[1:0], t16_event_pin_i};
        state_next.low_speed_internal_oscillator_sync = {state_reg.low_speed_internal_oscillator_sync[1:0], low_speed_internal_oscillator_clk_i};
        state_next.p8_lvl = p8_n;
        state_next.p16_lvl = p16_n;
        state_next.low_speed_internal_oscillator_lvl = low_speed_internal_oscillator_n;
        state_next.psc_cnt = state_reg.psc_cnt + 8'h01;
        state_next.div4 = state_reg.div4 + 2'h1;
        state_next.irq8 = ovf8 & int_en8_i;
        state_next.irq16 = ovf16 & int_en16_i;

        // Counting with reload of the preload value on overflow.
        if (ovf8) begin
            state_next.cnt8 = state_reg.pre8;
        end else if (inc8) begin
            state_next.cnt8 = state_reg.cnt8 + 8'h01;
        end
        if (ovf16) begin
            state_next.cnt16 = state_reg.pre16;
        end else if (inc16) begin
            state_next.cnt16 = state_reg.cnt16 + 16'h0001;
        end

        // Pulse width arm on the active edge, stop and clear run on return.
        if (state_reg.ctl8[DTEC_MODE_HI:DTEC_MODE_LO] == DTEC_MODE_PULSE
            && state_reg.ctl8[DTEC_RUN_BIT]) begin
            if (!state_reg.pw8 && beg8) begin
                state_next.pw8 = 1'b1;
            end else if (state_reg.pw8 && end8) begin
                state_next.pw8 = 1'b0;
                state_next.ctl8[DTEC_RUN_BIT] = 1'b0;
            end
        end
        if (ctl16_eff[DTEC_MODE_HI:DTEC_MODE_LO] == DTEC_MODE_PULSE
            && ctl16_eff[DTEC_RUN_BIT]) begin
            if (!state_reg.pw16 && beg16) begin
                state_next.pw16 = 1'b1;
            end else if (state_reg.pw16 && end16) begin
                state_next.pw16 = 1'b0;
                state_next.ctl16[DTEC_RUN_BIT] = 1'b0;
            end
        end

        // Writes: the count address is the preload register.
        if (wr_i) begin
            case (addr_i)
                DTEC_T8_COUNT: begin
                    state_next.pre8 = wdata_i;
                    if (!state_reg.ctl8[DTEC_RUN_BIT]) begin
                        state_next.cnt8 = wdata_i;
                    end
                end
                DTEC_T8_CONTROL: begin
                    state_next.ctl8 = wdata_i;
                    state_next.pw8 = 1'b0;
                end
                DTEC_T16_LOW: begin
                    state_next.lowbuf = wdata_i;
                end
                DTEC_T16_HIGH: begin
                    state_next.pre16 = {wdata_i, state_reg.lowbuf};
                    if (!state_reg.ctl16[DTEC_RUN_BIT]) begin
                        state_next.cnt16 = {wdata_i, state_reg.lowbuf};
                    end
                end
                DTEC_T16_CONTROL: begin
                    state_next.ctl16 = HAS_T16 ? wdata_i : DTEC_CTRL_RST;
                    state_next.pw16 = 1'b0;
                end
                default: begin
                end
            endcase
        end

        // Reads: high byte read latches the live low byte for later.
        if (rd_i) begin
            case (addr_i)
                DTEC_T8_COUNT: state_next.rdata = state_reg.cnt8;
                DTEC_T8_CONTROL: state_next.rdata = state_reg.ctl8;
                DTEC_T16_LOW: state_next.rdata = state_reg.lowbuf;
                DTEC_T16_HIGH: begin
                    state_next.rdata = state_reg.cnt16[15:8];
                    state_next.lowbuf = state_reg.cnt16[7:0];
                end
                DTEC_T16_CONTROL: state_next.rdata = ctl16_eff;
                default: state_next.rdata = 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Preload resets to zero, one legal instance of an unknown value.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= '0;
        end else if (ce_i) begin
            state_reg <= state_next;
        end
    end

    assign rdata_o = state_reg.rdata;
    assign irq8_o = state_reg.irq8;
    assign irq16_o = state_reg.irq16;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_idle_hold;
        @(posedge clock_i) disable iff (!nrst_i)
        (ce_i && !wr_i && state_reg.ctl8[DTEC_MODE_HI:DTEC_MODE_LO]
         == DTEC_MODE_IDLE) |=> $stable(state_reg.cnt8);
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("Idle 8-bit counter changed.");

    property p_halt_hold;
        @(posedge clock_i) disable iff (!nrst_i)
        (ce_i && !wr_i && !state_reg.ctl16[DTEC_RUN_BIT])
        |=> $stable(state_reg.cnt16);
    endproperty
    a_halt_hold: assert property (p_halt_hold)
        else $error("Halted 16-bit counter changed.");

    property p_reload;
        @(posedge clock_i) disable iff (!nrst_i)
        (ce_i && !wr_i && ovf8) |=> state_reg.cnt8 == $past(state_reg.pre8)
        && irq8_o == $past(int_en8_i);
    endproperty
    a_reload: assert property (p_reload)
        else $error("8-bit overflow did not reload or request.");

    property p_irq_gate;
        @(posedge clock_i) disable iff (!nrst_i)
        (ce_i && !int_en16_i) |=> !irq16_o;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("16-bit request passed a zero enable.");

    property p_wr_halted;
        @(posedge clock_i) disable iff (!nrst_i)
        (ce_i && wr_i && addr_i == DTEC_T8_COUNT
         && !state_reg.ctl8[DTEC_RUN_BIT]) |=> state_reg.cnt8 == $past(wdata_i);
    endproperty
    a_wr_halted: assert property (p_wr_halted)
        else $error("Halted preload write missed the counter.");

    property p_wr_running;
        @(posedge clock_i) disable iff (!nrst_i)
        (ce_i && wr_i && addr_i == DTEC_T8_COUNT && !ovf8
         && state_reg.ctl8[DTEC_RUN_BIT]) |=> state_reg.pre8 == $past(wdata_i)
        && (state_reg.cnt8 == $past(state_reg.cnt8)
            || state_reg.cnt8 == $past(state_reg.cnt8) + 8'h01);
    endproperty
    a_wr_running: assert property (p_wr_running)
        else $error("Running preload write disturbed the counter.");

    property p_low_write;
        @(posedge clock_i) disable iff (!nrst_i)
        (ce_i && wr_i && addr_i == DTEC_T16_LOW && !inc16)
        |=> $stable(state_reg.cnt16) && state_reg.lowbuf == $past(wdata_i);
    endproperty
    a_low_write: assert property (p_low_write)
        else $error("Low byte write reached the counter.");

    property p_high_write;
        @(posedge clock_i) disable iff (!nrst_i)
        (ce_i && wr_i && addr_i == DTEC_T16_HIGH
         && !state_reg.ctl16[DTEC_RUN_BIT])
        |=> state_reg.cnt16 == {$past(wdata_i), $past(state_reg.lowbuf)};
    endproperty
    a_high_write: assert property (p_high_write)
        else $error("High byte write did not pair with buffer.");

    property p_low_read;
        @(posedge clock_i) disable iff (!nrst_i)
        (ce_i && rd_i && addr_i == DTEC_T16_LOW)
        |=> rdata_o == $past(state_reg.lowbuf);
    endproperty
    a_low_read: assert property (p_low_read)
        else $error("Low byte read did not return the buffer.");

    property p_event;
        @(posedge clock_i) disable iff (!nrst_i)
        (ce_i && !wr_i && ev8 && state_reg.ctl8[DTEC_RUN_BIT]
         && state_reg.ctl8[DTEC_MODE_HI:DTEC_MODE_LO] == DTEC_MODE_EVENT
         && state_reg.cnt8 != DTEC_FULL8)
        |=> state_reg.cnt8 == $past(state_reg.cnt8) + 8'h01;
    endproperty
    a_event: assert property (p_event)
        else $error("Pin event did not add one.");

    property p_pulse_end;
        @(posedge clock_i) disable iff (!nrst_i)
        (ce_i && !wr_i && state_reg.pw8 && end8 && state_reg.ctl8[DTEC_RUN_BIT]
         && state_reg.ctl8[DTEC_MODE_HI:DTEC_MODE_LO] == DTEC_MODE_PULSE)
        |=> !state_reg.ctl8[DTEC_RUN_BIT] ##1 $stable(state_reg.cnt8);
    endproperty
    a_pulse_end: assert property (p_pulse_end)
        else $error("Pulse end did not clear run and stop.");

endmodule

/* testbench/dtec_event_src.sv */
// Model of the outside source that toggles the two counter event pins.
`timescale 1ns/1ns

module dtec_event_src (
    input wire logic clock_i, // System clock, used only to pace edges.
    output logic pin8_o,      // Event line of the 8-bit counter.
    output logic pin16_o      // Event line of the 16-bit counter.
);
    // ****************************************************************
    // Pulse generation
    // ****************************************************************

    // Both lines rest low until a pulse train is asked for.
    initial begin
        pin8_o = 1'b0;
        pin16_o = 1'b0;
    end

    // Sends n pulses away from the rest level, each level held w cycles.
    // Every pulse has one rising and one falling edge.
    // The hold is kept well past the pin filter, so no edge is dropped.
    task automatic pulse(input bit sel, input int n, input int w);
        for (int i = 0; i < 2 * n; i++) begin
            repeat (w) @(posedge clock_i);
            if (sel) begin
                pin16_o <= ~pin16_o;
            end else begin
                pin8_o <= ~pin8_o;
            end
        end
    endtask
endmodule

/* testbench/dtec_top_bench.sv */
// Self-checking bench for the dual timer/event counter block.
`timescale 1ns/1ns

module dtec_top_bench import dtec_pkg::*; ();
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic ce_i = 1'b1;
    logic [2:0] addr_i = 3'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] wdata_i = 8'h00;
    logic low_speed_internal_oscillator_clk_i = 1'b0;
    logic int_en8_i = 1'b0;
    logic int_en16_i = 1'b0;
    logic t8_pin;
    logic t16_pin;
    logic [7:0] rdata_o;
    logic irq8_o;
    logic irq16_o;
    logic [7:0] d;
    int error_cnt = 0;
    int cmp_count = 0;
    int irq8_seen = 0;
    int irq16_seen = 0;

    // ****************************************************************
    // Design, event source and clocks
    // ****************************************************************
    dtec_top i_dut (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i),
        .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i),
        .t8_pin_i(t8_pin), .t16_event_pin_i(t16_pin),
        .low_speed_internal_oscillator_clk_i(low_speed_internal_oscillator_clk_i), .int_en8_i(int_en8_i),
        .int_en16_i(int_en16_i), .rdata_o(rdata_o), .irq8_o(irq8_o),
        .irq16_o(irq16_o));
    dtec_event_src i_src (.clock_i(clock_i), .pin8_o(t8_pin),
        .pin16_o(t16_pin));

    // System clock at 100 MHz.
    always #5 clock_i = ~clock_i;

    // Slow oscillator: one rising edge every 20 system cycles.
    always begin
        repeat (10) @(posedge clock_i);
        low_speed_internal_oscillator_clk_i <= ~low_speed_internal_oscillator_clk_i;
    end

    // Overflow request pulses are tallied so a lost or extra one shows.
    always @(posedge clock_i) begin
        if (irq8_o === 1'b1) irq8_seen++;
        if (irq16_o === 1'b1) irq16_seen++;
    end

    // ****************************************************************
    // Register access and comparison tasks
    // ****************************************************************
    function automatic logic [7:0] ctl(logic [1:0] m, bit s, bit r, bit e,
                                       logic [2:0] p);
        return {m, s, r, e, p};
    endfunction

    // One write, taken at the edge after the strobe rises.
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask

    // One read; the data stands from the taking edge and is picked up at
    // the next edge, so it is never sampled in the step that launches it.
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        @(posedge clock_i);
        v = rdata_o;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Range check, for counts whose exact phase against a tick is free.
    task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo,
                           input logic [7:0] hi);
        cmp_count++;
        if (!(got >= lo && got <= hi) || $isunknown(got)) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h to %h", $time,
                     got, lo, hi);
        end
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        repeat (2) @(posedge clock_i);
        nrst_i <= 1'b1;
        // All five registers read zero after reset, unmapped index 5 too.
        for (int a = 0; a < 6; a++) begin
            rd(3'(a), d);
            chk(d, 8'h00);
        end
        // Halted preload lands in the counter; idle mode never counts.
        wr(DTEC_T8_COUNT, 8'ha5);
        wr(DTEC_T8_CONTROL, ctl(DTEC_MODE_IDLE, 0, 1, 0, 3'h0));
        repeat (20) @(posedge clock_i);
        rd(DTEC_T8_COUNT, d);
        chk(d, 8'ha5);
        rd(DTEC_T8_CONTROL, d);
        chk(d, ctl(DTEC_MODE_IDLE, 0, 1, 0, 3'h0));
        // Running preload write waits for the overflow, then reloads.
        // The counter is halted first so the start value lands at once.
        int_en8_i <= 1'b1;
        wr(DTEC_T8_CONTROL, DTEC_CTRL_RST);
        wr(DTEC_T8_COUNT, 8'hf0);
        wr(DTEC_T8_CONTROL, ctl(DTEC_MODE_TIMER, 0, 1, 0, 3'h0));
        wr(DTEC_T8_COUNT, 8'h10);
        rd(DTEC_T8_COUNT, d);
        chk_rng(d, 8'hf2, 8'hf8);
        repeat (20) @(posedge clock_i);
        wr(DTEC_T8_CONTROL, ctl(DTEC_MODE_TIMER, 0, 0, 0, 3'h0));
        chk(8'(irq8_seen), 8'h01);
        rd(DTEC_T8_COUNT, d);
        chk_rng(d, 8'h14, 8'h20);
        // With the request enable low an overflow raises nothing.
        int_en8_i <= 1'b0;
        wr(DTEC_T8_COUNT, 8'hfe);
        wr(DTEC_T8_CONTROL, ctl(DTEC_MODE_TIMER, 0, 1, 0, 3'h0));
        repeat (10) @(posedge clock_i);
        wr(DTEC_T8_CONTROL, ctl(DTEC_MODE_TIMER, 0, 0, 0, 3'h0));
        chk(8'(irq8_seen), 8'h01);
        // Prescale field 3: one tick every eight cycles.
        wr(DTEC_T8_COUNT, 8'h00);
        wr(DTEC_T8_CONTROL, ctl(DTEC_MODE_TIMER, 0, 1, 0, 3'h3));
        repeat (80) @(posedge clock_i);
        wr(DTEC_T8_CONTROL, ctl(DTEC_MODE_TIMER, 0, 0, 0, 3'h3));
        rd(DTEC_T8_COUNT, d);
        chk_rng(d, 8'h09, 8'h0b);
        // Event mode counts pin edges, prescale ignored, both polarities.
        wr(DTEC_T8_COUNT, 8'h00);
        wr(DTEC_T8_CONTROL, ctl(DTEC_MODE_EVENT, 0, 1, 0, 3'h7));
        i_src.pulse(0, 5, 8);
        repeat (8) @(posedge clock_i);
        rd(DTEC_T8_COUNT, d);
        chk(d, 8'h05);
        wr(DTEC_T8_CONTROL, ctl(DTEC_MODE_EVENT, 0, 1, 1, 3'h7));
        i_src.pulse(0, 3, 8);
        repeat (8) @(posedge clock_i);
        rd(DTEC_T8_COUNT, d);
        chk(d, 8'h08);
        // Pulse mode waits for the start edge, times it, drops run.
        // Halt first: a preload write while running would not clear it.
        wr(DTEC_T8_CONTROL, ctl(DTEC_MODE_PULSE, 0, 0, 1, 3'h0));
        wr(DTEC_T8_COUNT, 8'h00);
        wr(DTEC_T8_CONTROL, ctl(DTEC_MODE_PULSE, 0, 1, 1, 3'h0));
        i_src.pulse(0, 1, 30);
        repeat (8) @(posedge clock_i);
        rd(DTEC_T8_CONTROL, d);
        chk(d, ctl(DTEC_MODE_PULSE, 0, 0, 1, 3'h0));
        rd(DTEC_T8_COUNT, d);
        chk_rng(d, 8'h1c, 8'h20);
        // Buffered byte access of the 16-bit counter.
        wr(DTEC_T16_LOW, 8'h34);
        wr(DTEC_T16_HIGH, 8'h12);
        rd(DTEC_T16_HIGH, d);
        chk(d, 8'h12);
        rd(DTEC_T16_LOW, d);
        chk(d, 8'h34);
        wr(DTEC_T16_LOW, 8'h99);
        rd(DTEC_T16_HIGH, d);
        chk(d, 8'h12);
        rd(DTEC_T16_LOW, d);
        chk(d, 8'h34);
        // A write made while the clock enable is low must be lost.
        ce_i <= 1'b0;
        wr(DTEC_T16_HIGH, 8'h56);
        ce_i <= 1'b1;
        rd(DTEC_T16_HIGH, d);
        chk(d, 8'h12);
        // Both internal sources of the 16-bit counter.
        for (int s = 0; s < 2; s++) begin
            wr(DTEC_T16_LOW, 8'h00);
            wr(DTEC_T16_HIGH, 8'h00);
            wr(DTEC_T16_CONTROL, ctl(DTEC_MODE_TIMER, s[0], 1, 0, 3'h0));
            repeat (s ? 200 : 40) @(posedge clock_i);
            wr(DTEC_T16_CONTROL, ctl(DTEC_MODE_TIMER, s[0], 0, 0, 3'h0));
            rd(DTEC_T16_HIGH, d);
            chk(d, 8'h00);
            rd(DTEC_T16_LOW, d);
            chk_rng(d, 8'h08, 8'h0c);
        end
        // 16-bit event overflow raises one request and reloads.
        int_en16_i <= 1'b1;
        wr(DTEC_T16_LOW, 8'hfe);
        wr(DTEC_T16_HIGH, 8'hff);
        wr(DTEC_T16_CONTROL, ctl(DTEC_MODE_EVENT, 0, 1, 0, 3'h0));
        i_src.pulse(1, 2, 8);
        repeat (8) @(posedge clock_i);
        chk(8'(irq16_seen), 8'h01);
        rd(DTEC_T16_HIGH, d);
        chk(d, 8'hff);
        rd(DTEC_T16_LOW, d);
        chk(d, 8'hfe);
        close_out();
    end

    // Watchdog: the sequence needs about 770 cycles, so some 26 times that.
    initial begin
        repeat (20000) @(posedge clock_i);
        error_cnt++;
        close_out();
    end
endmodule
